//--- logic/lldc_pkg.sv
// shared constants and types for the dram command and mode control block
package lldc_pkg;
  // operating mode word loaded by a mode-set
  localparam int MODE_WIDTH = 18;
  localparam logic [17:0] MODE_RESET = 18'h00000;
  localparam int DLL_EN_POS = 7;
  localparam int IMP_CTRL_POS = 8;
  localparam int TERM_EN_POS = 9;

  // banks and refresh rows
  localparam int BANK_BITS = 3;
  localparam int NUM_BANKS = 8;

  // consecutive mode-sets before the one that resets internal logic
  localparam logic [1:0] MODE_RUN_RESET = 2'h2;
  localparam logic [1:0] MODE_RUN_MAX = 2'h3;

  // dll lock wait, in link clock cycles
  localparam int DLL_CNT_BITS = 10;
  localparam logic [9:0] DLL_LOCK_LAST = 10'h3FF;

  // impedance calibration sampling on the core clock
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int CAL_INTERVAL_NS = 1000;
  localparam int CAL_INTERVAL_CYCLES =
    (CAL_INTERVAL_NS / CLOCK_PERIOD_NS < 1) ? 1 :
    CAL_INTERVAL_NS / CLOCK_PERIOD_NS;
  localparam int CAL_CNT_BITS = 8;
  localparam int DRIVE_CODE_BITS = 6;
  // midscale code gives the nominal 50 ohm driver
  localparam logic [5:0] DRIVE_CODE_NOMINAL = 6'h20;
  localparam logic [5:0] DRIVE_CODE_MAX = 6'h3F;
  localparam logic [5:0] DRIVE_CODE_MIN = 6'h00;

  // decoded command, one-hot
  typedef enum logic [4:0] {
    CMD_NOP = 5'h01,
    CMD_MODE = 5'h02,
    CMD_READ = 5'h04,
    CMD_WRITE = 5'h08,
    CMD_REFRESH = 5'h10
  } lldc_cmd_type;

  // dll state, one-hot
  typedef enum logic [2:0] {
    DLL_OFF = 3'h1,
    DLL_LOCKING = 3'h2,
    DLL_LOCKED = 3'h4
  } lldc_dll_type;
endpackage

//--- logic/lldc_sync.sv
// two flip-flop synchroniser for levels entering a clock domain
module lldc_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input wire logic clk_in,
  // asynchronous levels
  input wire logic [WIDTH-1:0] d_in,
  // synchronised levels
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } lldc_sync_type;

  lldc_sync_type st;
  lldc_sync_type next_st;

  always_comb
  begin
    next_st.stage1 = d_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_in)
  begin
    st <= next_st;
  end

  assign q_out = st.stage2;
endmodule

//--- logic/lldc_ctrl.sv
// command decode, mode register, refresh, dll, termination and calibration
// What this block and its controller must do
// R1: controller should drive all address pins low during dummy mode-sets.
// R2: controller holds address bits 10 to 17 low in power-up mode-sets.
// R3: controller resets the dll after clock period or supply changes.
// R4: init issues eight bank refreshes among 1024 no-ops, in any order.
// R5: controller waits one row cycle after a refresh before same bank use.
// R6: dll enable bit resets low and then the dll stays disabled.
// R7: controller waits 1024 clocks after enabling dll before any read.
// R8: dll reset is enable low, recovery wait, enable high, 1024 clocks.
// R9: impedance control bit high sets driver from the external resistor.
// R10: when enabled, periodic resampling updates impedance undisturbed.
// R11: impedance bit low compensates against internal reference near 50 ohm.
// R12: termination bit set terminates data and mask pins only.
// R13: data pin termination drops while driving; mask keeps termination.
// R14: chip select high is no-op; write enable and refresh pick command.
// R15: other control combinations are reserved and never issued.
// R16: command, address and control pins register on rising link clock.
// R17: deselect leaves running work alone and accepts no commands.
// R18: controller issues mode-set only with banks idle, no bursts.
// R19: mode-set loads the mode register from address bits 0 to 17.
// R20: read and write take bank from bank select, location from address.
// R21: write beats with mask low are stored, mask high are dropped.
// R22: bank refresh uses internal row counter; address pins are ignored.
// R23: controller gives only no-ops for 200 us at power-up.
// R24: three or more consecutive mode-sets reset internal logic.
// R25: controller gives only no-ops for recovery time after a mode-set.
// R26: each bank has its own refresh row counter, advanced per refresh.
module lldc_ctrl #(
  parameter int ADDR_WIDTH = 21,
  parameter int DATA_WIDTH = 36,
  parameter int ROW_BITS = 13
) (
  // core clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // link clock and command pins
  input wire logic link_clk_in,
  input wire logic cs_n_in,
  input wire logic we_n_in,
  input wire logic ref_n_in,
  input wire logic [ADDR_WIDTH-1:0] addr_in,
  input wire logic [lldc_pkg::BANK_BITS-1:0] bank_select_in,
  // write beats from the data capture, link domain
  input wire logic wr_beat_valid_in,
  input wire logic [DATA_WIDTH-1:0] wr_beat_data_in,
  input wire logic write_byte_mask_in,
  // read path driving the data pins, link domain
  input wire logic dq_driving_in,
  // calibration comparators, asynchronous
  input wire logic cal_ext_cmp_in,
  input wire logic cal_int_cmp_in,
  // decoded array commands
  output logic rd_cmd_out,
  output logic wr_cmd_out,
  output logic [lldc_pkg::BANK_BITS-1:0] cmd_bank_out,
  output logic [ADDR_WIDTH-1:0] cmd_addr_out,
  // refresh to the array
  output logic refresh_out,
  output logic [lldc_pkg::BANK_BITS-1:0] refresh_bank_out,
  output logic [ROW_BITS-1:0] refresh_row_out,
  // masked write beats to the array
  output logic mem_wr_en_out,
  output logic [DATA_WIDTH-1:0] mem_wr_data_out,
  output logic [lldc_pkg::BANK_BITS-1:0] mem_wr_bank_out,
  output logic [ADDR_WIDTH-1:0] mem_wr_addr_out,
  // mode and dll status
  output logic [lldc_pkg::MODE_WIDTH-1:0] operating_mode_config_out,
  output logic dll_enable_out,
  output logic dll_locked_out,
  output logic internal_reset_out,
  // termination enables
  output logic dq_term_en_out,
  output logic dm_term_en_out,
  // driver impedance, core domain
  output logic [lldc_pkg::DRIVE_CODE_BITS-1:0] drive_code_out,
  output logic cal_ext_sel_out,
  output logic cal_update_out
);
  typedef struct packed {
    logic [lldc_pkg::MODE_WIDTH-1:0] mode;
    logic [1:0] mode_run;
    lldc_pkg::lldc_dll_type dll_state;
    logic [lldc_pkg::DLL_CNT_BITS-1:0] dll_cnt;
    logic [lldc_pkg::NUM_BANKS-1:0][ROW_BITS-1:0] rows;
    logic rd;
    logic wr;
    logic [lldc_pkg::BANK_BITS-1:0] cmd_bank;
    logic [ADDR_WIDTH-1:0] cmd_addr;
    logic refr;
    logic [lldc_pkg::BANK_BITS-1:0] ref_bank;
    logic [ROW_BITS-1:0] ref_row;
    logic [lldc_pkg::BANK_BITS-1:0] wr_bank;
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic mem_we;
    logic [DATA_WIDTH-1:0] mem_data;
    logic [lldc_pkg::BANK_BITS-1:0] mem_bank;
    logic [ADDR_WIDTH-1:0] mem_addr;
    logic term_dq;
    logic term_dm;
    logic int_rst;
  } lldc_link_type;

  typedef struct packed {
    logic [lldc_pkg::DRIVE_CODE_BITS-1:0] drive_code;
    logic ext_sel;
    logic [lldc_pkg::CAL_CNT_BITS-1:0] tick_cnt;
    logic upd;
  } lldc_core_type;

  localparam logic [lldc_pkg::CAL_CNT_BITS-1:0] CAL_LAST =
    lldc_pkg::CAL_CNT_BITS'(lldc_pkg::CAL_INTERVAL_CYCLES - 1);

  lldc_link_type ls;
  lldc_link_type next_ls;
  lldc_core_type cs;
  lldc_core_type next_cs;
  lldc_pkg::lldc_cmd_type cmd;
  logic link_rst;
  logic [3:0] core_sync;
  logic imp_s;
  logic drv_s;
  logic ext_cmp_s;
  logic int_cmp_s;
  logic cmp;

  // reset reaches the link domain as a level, two link edges late
  lldc_sync #(
    .WIDTH(1)
  ) u_link_rst_sync (
    .clk_in(link_clk_in),
    .d_in(srst_in),
    .q_out(link_rst)
  );

  // mode bit is quasi-static: it only changes with all banks idle
  lldc_sync #(
    .WIDTH(4)
  ) u_core_sync (
    .clk_in(clock_in),
    .d_in({ls.mode[lldc_pkg::IMP_CTRL_POS], dq_driving_in,
      cal_ext_cmp_in, cal_int_cmp_in}),
    .q_out(core_sync)
  );

  assign imp_s = core_sync[3];
  assign drv_s = core_sync[2];
  assign ext_cmp_s = core_sync[1];
  assign int_cmp_s = core_sync[0];

  // R14: command decode
  // R15: all four chip-select-low codes are defined, nothing left over
  always_comb
  begin
    if (cs_n_in)
      cmd = lldc_pkg::CMD_NOP;
    else if (!we_n_in && !ref_n_in)
      cmd = lldc_pkg::CMD_MODE;
    else if (we_n_in && ref_n_in)
      cmd = lldc_pkg::CMD_READ;
    else if (!we_n_in)
      cmd = lldc_pkg::CMD_WRITE;
    else
      cmd = lldc_pkg::CMD_REFRESH;
  end

  always_comb
  begin
    next_ls = ls;
    next_ls.rd = 1'b0;
    next_ls.wr = 1'b0;
    next_ls.refr = 1'b0;
    next_ls.mem_we = 1'b0;
    next_ls.int_rst = 1'b0;
    next_ls.mode_run = 2'h0;
    // R7: lock wait of 1024 link cycles
    if (ls.dll_state == lldc_pkg::DLL_LOCKING)
    begin
      if (ls.dll_cnt == lldc_pkg::DLL_LOCK_LAST)
        next_ls.dll_state = lldc_pkg::DLL_LOCKED;
      else
        next_ls.dll_cnt = ls.dll_cnt + 10'h001;
    end
    // R21: masked beats never reach the array
    if (wr_beat_valid_in)
    begin
      if (!write_byte_mask_in)
      begin
        next_ls.mem_we = 1'b1;
        next_ls.mem_data = wr_beat_data_in;
        next_ls.mem_bank = ls.wr_bank;
        next_ls.mem_addr = ls.wr_addr;
      end
      next_ls.wr_addr = ls.wr_addr + ADDR_WIDTH'(1);
    end
    // R16: pins are taken on the rising link edge
    // R17: no-op changes nothing already running
    case (cmd)
      lldc_pkg::CMD_MODE:
      begin
        // R19: only the low 18 address bits are stored
        next_ls.mode = addr_in[lldc_pkg::MODE_WIDTH-1:0];
        if (ls.mode_run != lldc_pkg::MODE_RUN_MAX)
          next_ls.mode_run = ls.mode_run + 2'h1;
        else
          next_ls.mode_run = ls.mode_run;
        // R24: third consecutive mode-set resets internal logic
        if (ls.mode_run >= lldc_pkg::MODE_RUN_RESET)
        begin
          next_ls.int_rst = 1'b1;
          next_ls.rows = '0;
        end
        // R6: bit low keeps the dll disabled
        // R8: low then high restarts the lock wait
        if (!addr_in[lldc_pkg::DLL_EN_POS])
        begin
          next_ls.dll_state = lldc_pkg::DLL_OFF;
          next_ls.dll_cnt = '0;
        end
        else if (ls.dll_state == lldc_pkg::DLL_OFF ||
          ls.mode_run >= lldc_pkg::MODE_RUN_RESET)
        begin
          next_ls.dll_state = lldc_pkg::DLL_LOCKING;
          next_ls.dll_cnt = '0;
        end
      end
      lldc_pkg::CMD_READ:
      begin
        // R20: bank and location captured with the command
        next_ls.rd = 1'b1;
        next_ls.cmd_bank = bank_select_in;
        next_ls.cmd_addr = addr_in;
      end
      lldc_pkg::CMD_WRITE:
      begin
        next_ls.wr = 1'b1;
        next_ls.cmd_bank = bank_select_in;
        next_ls.cmd_addr = addr_in;
        next_ls.wr_bank = bank_select_in;
        next_ls.wr_addr = addr_in;
      end
      lldc_pkg::CMD_REFRESH:
      begin
        // R22: row from the bank counter, address pins unused
        // R26: only the addressed bank counter advances
        next_ls.refr = 1'b1;
        next_ls.ref_bank = bank_select_in;
        next_ls.ref_row = ls.rows[bank_select_in];
        next_ls.rows[bank_select_in] =
          ls.rows[bank_select_in] + ROW_BITS'(1);
      end
      default:
      begin
        next_ls.mode_run = 2'h0;
      end
    endcase
    // R12: data and mask terminate only when the bit is set
    // R13: data termination drops while the pins drive
    next_ls.term_dm = ls.mode[lldc_pkg::TERM_EN_POS];
    next_ls.term_dq = ls.mode[lldc_pkg::TERM_EN_POS] && !dq_driving_in;
  end

  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      ls <= '0;
      ls.mode <= lldc_pkg::MODE_RESET;
      ls.dll_state <= lldc_pkg::DLL_OFF;
    end
    else
    begin
      ls <= next_ls;
    end
  end

  // R11: internal reference comparator when the bit is low
  // R9: external resistor comparator when the bit is high
  assign cmp = cs.ext_sel ? ext_cmp_s : int_cmp_s;

  always_comb
  begin
    next_cs = cs;
    next_cs.upd = 1'b0;
    next_cs.ext_sel = imp_s;
    if (cs.ext_sel != imp_s)
    begin
      // new reference: restart from the nominal code
      next_cs.drive_code = lldc_pkg::DRIVE_CODE_NOMINAL;
      next_cs.tick_cnt = '0;
    end
    else if (cs.tick_cnt == CAL_LAST)
    begin
      // R10: update held off while driving so timing is not disturbed
      if (!drv_s)
      begin
        next_cs.tick_cnt = '0;
        next_cs.upd = 1'b1;
        if (cmp && cs.drive_code != lldc_pkg::DRIVE_CODE_MAX)
          next_cs.drive_code = cs.drive_code + 6'h01;
        else if (!cmp && cs.drive_code != lldc_pkg::DRIVE_CODE_MIN)
          next_cs.drive_code = cs.drive_code - 6'h01;
      end
    end
    else
    begin
      next_cs.tick_cnt = cs.tick_cnt + 8'h01;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      cs <= '0;
      cs.drive_code <= lldc_pkg::DRIVE_CODE_NOMINAL;
    end
    else
    begin
      cs <= next_cs;
    end
  end

  assign rd_cmd_out = ls.rd;
  assign wr_cmd_out = ls.wr;
  assign cmd_bank_out = ls.cmd_bank;
  assign cmd_addr_out = ls.cmd_addr;
  assign refresh_out = ls.refr;
  assign refresh_bank_out = ls.ref_bank;
  assign refresh_row_out = ls.ref_row;
  assign mem_wr_en_out = ls.mem_we;
  assign mem_wr_data_out = ls.mem_data;
  assign mem_wr_bank_out = ls.mem_bank;
  assign mem_wr_addr_out = ls.mem_addr;
  assign operating_mode_config_out = ls.mode;
  assign dll_enable_out = ls.mode[lldc_pkg::DLL_EN_POS];
  assign dll_locked_out = (ls.dll_state == lldc_pkg::DLL_LOCKED);
  assign internal_reset_out = ls.int_rst;
  assign dq_term_en_out = ls.term_dq;
  assign dm_term_en_out = ls.term_dm;
  assign drive_code_out = cs.drive_code;
  assign cal_ext_sel_out = cs.ext_sel;
  assign cal_update_out = cs.upd;

  a_dll_off_low: assert property ( // R6
    @(posedge link_clk_in) disable iff (link_rst)
    !ls.mode[lldc_pkg::DLL_EN_POS] |-> !dll_locked_out)
    else $error("dll reported locked with enable bit low");

  a_dll_lock_wait: assert property ( // R7
    @(posedge link_clk_in) disable iff (link_rst)
    $rose(dll_locked_out) |->
      $past(ls.dll_cnt) == lldc_pkg::DLL_LOCK_LAST)
    else $error("dll locked before 1024 cycles");

  a_mode_load_bits: assert property ( // R19
    @(posedge link_clk_in) disable iff (link_rst)
    (!cs_n_in && !we_n_in && !ref_n_in) |=>
      operating_mode_config_out ==
      $past(addr_in[lldc_pkg::MODE_WIDTH-1:0]))
    else $error("mode register not loaded from address");

  a_read_bank_sel: assert property ( // R20
    @(posedge link_clk_in) disable iff (link_rst)
    (!cs_n_in && we_n_in && ref_n_in) |=>
      rd_cmd_out && !wr_cmd_out && cmd_bank_out == $past(bank_select_in))
    else $error("read not decoded with its bank");

  a_deselect_quiet: assert property ( // R17
    @(posedge link_clk_in) disable iff (link_rst)
    cs_n_in |=> !rd_cmd_out && !wr_cmd_out && !refresh_out)
    else $error("command accepted while deselected");

  a_mask_drops_beat: assert property ( // R21
    @(posedge link_clk_in) disable iff (link_rst)
    (wr_beat_valid_in && write_byte_mask_in) |=> !mem_wr_en_out)
    else $error("masked beat written");

  a_unmasked_beat: assert property ( // R21
    @(posedge link_clk_in) disable iff (link_rst)
    (wr_beat_valid_in && !write_byte_mask_in) |=>
      mem_wr_en_out && mem_wr_data_out == $past(wr_beat_data_in))
    else $error("unmasked beat not written");

  a_refresh_bank_take: assert property ( // R22
    @(posedge link_clk_in) disable iff (link_rst)
    (!cs_n_in && we_n_in && !ref_n_in) |=>
      refresh_out && !rd_cmd_out && !wr_cmd_out &&
      refresh_bank_out == $past(bank_select_in))
    else $error("bank refresh not decoded with its bank");

  a_mode_run_reset: assert property ( // R24
    @(posedge link_clk_in) disable iff (link_rst)
    (!cs_n_in && !we_n_in && !ref_n_in) [*3] |=> internal_reset_out)
    else $error("three mode-sets did not reset logic");

  a_term_while_drive: assert property ( // R13
    @(posedge link_clk_in) disable iff (link_rst)
    dq_driving_in |=> !dq_term_en_out &&
      dm_term_en_out == $past(ls.mode[lldc_pkg::TERM_EN_POS]))
    else $error("termination wrong while driving");

  a_cal_hold_drive: assert property ( // R10
    @(posedge clock_in) disable iff (srst_in)
    (drv_s && cs.ext_sel == imp_s) |=>
      !cal_update_out && $stable(drive_code_out))
    else $error("impedance updated while driving");
endmodule

//--- testbench/lldc_host.sv
// host memory controller model driving command and write beat pins
module lldc_host (
  // link clock
  input wire logic link_clk_in,
  // command pins
  output logic cs_n_out,
  output logic we_n_out,
  output logic ref_n_out,
  output logic [20:0] addr_out,
  output logic [2:0] bank_out,
  // write beats and read path activity
  output logic beat_valid_out,
  output logic [35:0] beat_data_out,
  output logic mask_out,
  output logic driving_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {cs_n_out, we_n_out, ref_n_out, beat_valid_out} = 4'hE;
    {addr_out, bank_out, beat_data_out, mask_out, driving_out} = '0;
  end

  // only the five legal codes, issued with banks idle
  task automatic cmd(input logic [2:0] code, input logic [20:0] a,
    input logic [2:0] b);
    {cs_n_out, we_n_out, ref_n_out} <= code;
    {addr_out, bank_out} <= {a, b};
    beat_valid_out <= 1'b0;
    // data lines are not valid between beats: keep them moving
    beat_data_out <= ~beat_data_out;
    @(negedge link_clk_in);
  endtask

  // one beat a cycle with its mask
  task automatic beat(input logic m, input logic [35:0] d);
    {cs_n_out, beat_valid_out, mask_out} <= {2'h3, m};
    beat_data_out <= d;
    @(negedge link_clk_in);
  endtask

  // read path drives the data pins
  task automatic drive_dq(input logic v);
    driving_out <= v;
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the dram command and mode control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] MS = 3'h0;
  localparam logic [2:0] WR = 3'h1;
  localparam logic [2:0] RF = 3'h2;
  localparam logic [2:0] RD = 3'h3;
  // recovery gap after a mode-set, a plain default
  localparam int MRSC = 6;
  localparam int LIMIT = 9000;
  logic clock_in = 1'b0;
  logic link_clk = 1'b0;
  logic srst_in = 1'b1;
  logic cal_ext = 1'b0;
  logic cal_int = 1'b0;
  logic cs_n, we_n, ref_n, beat_v, mask, drv;
  logic rd, wr, rf_p, mem_en, int_rst, dll_en, locked;
  logic dq_t, dm_t, cal_sel, cal_upd;
  logic [2:0] bank, cbank, rbank, mbank;
  logic [20:0] addr, caddr, maddr;
  logic [35:0] bdata, mdata;
  logic [12:0] row;
  logic [17:0] mode;
  logic [5:0] code;
  logic [12:0] rows [8] = '{default: 13'h0};
  logic [17:0] exp_mode = 18'h0;
  logic [20:0] waddr;
  logic [2:0] wbank;
  logic dll_on = 1'b0;
  logic skip_dq = 1'b0;
  int age = 0;
  int run = 0;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int total, gap;
  int order[$] = '{0, 1, 2, 3, 4, 5, 6, 7};

  always #50 clock_in = ~clock_in;
  always #16 link_clk = ~link_clk;

  lldc_host lldc_host_i (
    .link_clk_in(link_clk),
    .cs_n_out(cs_n),
    .we_n_out(we_n),
    .ref_n_out(ref_n),
    .addr_out(addr),
    .bank_out(bank),
    .beat_valid_out(beat_v),
    .beat_data_out(bdata),
    .mask_out(mask),
    .driving_out(drv)
  );

  lldc_ctrl lldc_ctrl_i (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .link_clk_in(link_clk),
    .cs_n_in(cs_n),
    .we_n_in(we_n),
    .ref_n_in(ref_n),
    .addr_in(addr),
    .bank_select_in(bank),
    .wr_beat_valid_in(beat_v),
    .wr_beat_data_in(bdata),
    .write_byte_mask_in(mask),
    .dq_driving_in(drv),
    .cal_ext_cmp_in(cal_ext),
    .cal_int_cmp_in(cal_int),
    .rd_cmd_out(rd),
    .wr_cmd_out(wr),
    .cmd_bank_out(cbank),
    .cmd_addr_out(caddr),
    .refresh_out(rf_p),
    .refresh_bank_out(rbank),
    .refresh_row_out(row),
    .mem_wr_en_out(mem_en),
    .mem_wr_data_out(mdata),
    .mem_wr_bank_out(mbank),
    .mem_wr_addr_out(maddr),
    .operating_mode_config_out(mode),
    .dll_enable_out(dll_en),
    .dll_locked_out(locked),
    .internal_reset_out(int_rst),
    .dq_term_en_out(dq_t),
    .dm_term_en_out(dm_t),
    .drive_code_out(code),
    .cal_ext_sel_out(cal_sel),
    .cal_update_out(cal_upd)
  );

  task automatic wrap_up;
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check_val(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [20:0] mword(input logic [2:0] hi);
    return {3'($urandom), 8'h00, hi, 7'($urandom)};
  endfunction

  function automatic logic [5:0] sat(input logic [5:0] p, input logic up);
    if (up)
      return (p == 6'h3F) ? p : p + 6'h01;
    return (p == 6'h00) ? p : p - 6'h01;
  endfunction

  // one link cycle of the reference model
  task automatic issue(input logic [2:0] c, input logic [20:0] a,
    input logic [2:0] b);
    logic t9;
    t9 = exp_mode[9];
    lldc_host_i.cmd(c, a, b);
    run = (c == MS) ? run + 1 : 0;
    age++;
    if (c == MS)
      exp_mode = a[17:0];
    if (c == MS && !a[7])
      dll_on = 1'b0;
    if (c == MS && a[7] && (!dll_on || run >= 3))
    begin
      dll_on = 1'b1;
      age = 0;
    end
    if (run >= 3)
      rows = '{default: 13'h0};
    check_val({rd, wr, rf_p}, {c == RD, c == WR, c == RF});
    check_val(int_rst, run >= 3);
    check_val(mode, exp_mode);
    check_val({dll_en, locked}, {exp_mode[7], dll_on && age >= 1024});
    check_val(dm_t, t9);
    if (!skip_dq)
      check_val(dq_t, t9 && !drv);
    skip_dq = 1'b0;
    if (c == RD || c == WR)
      check_val({cbank, caddr}, {b, a});
    if (c == WR)
      {wbank, waddr} = {b, a};
    if (c == RF)
    begin
      check_val({rbank, row}, {b, rows[b]});
      rows[b]++;
    end
  endtask

  task automatic nop_run(input int n);
    repeat (n)
      issue({1'b1, 2'($urandom)}, 21'($urandom), 3'($urandom));
  endtask

  task automatic wbeat(input logic m);
    logic [35:0] d;
    d = {4'($urandom), $urandom};
    lldc_host_i.beat(m, d);
    run = 0;
    age++;
    check_val(mem_en, !m);
    if (!m)
      check_val(mdata, d);
    if (!m)
      check_val({mbank, maddr}, {wbank, waddr});
    waddr++;
  endtask

  task automatic set_drv(input logic v);
    lldc_host_i.drive_dq(v);
    skip_dq = 1'b1;
    nop_run(3);
  endtask

  // unused comparator points the other way, exposing a wrong pick
  task automatic cal_run(input logic up, input logic ext);
    logic [5:0] prev;
    int seen;
    seen = 0;
    @(negedge clock_in);
    {cal_ext, cal_int} = ext ? {up, !up} : {!up, up};
    repeat (4) @(negedge clock_in);
    prev = code;
    for (int i = 0; i < 60 && seen < 3; i++)
    begin
      @(negedge clock_in);
      if (cal_upd === 1'b1)
      begin
        seen++;
        check_val(code, sat(prev, up));
      end
      prev = code;
    end
    check_val(36'(seen), 36'h3);
    check_val(cal_sel, ext);
    // back onto the link phase so the next command is sampled in time
    @(negedge link_clk);
  endtask

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      wrap_up();
    end
  end

  initial
  begin
    void'($urandom(32'h9913));
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
    check_val({code, cal_sel}, {6'h20, 1'b0});
    srst_in = 1'b0;
    repeat (4) @(negedge link_clk);
    check_val({mode, dll_en, locked}, 36'h0);
    nop_run(6250);
    issue(MS, 21'h0, 3'h0);
    issue(MS, 21'h0, 3'h0);
    issue(MS, mword(3'h0), 3'($urandom));
    nop_run(MRSC);
    order.shuffle();
    total = 0;
    foreach (order[i])
    begin
      gap = $urandom_range(120);
      nop_run(gap);
      total += gap;
      issue(RF, 21'($urandom), 3'(order[i]));
    end
    nop_run(1024 - total);
    issue(MS, mword(3'h5), 3'h0);
    nop_run(1030);
    set_drv(1'b1);
    // long enough for the calibration tick to stall on driving
    nop_run(60);
    set_drv(1'b0);
    issue(MS, mword(3'h4), 3'h0);
    nop_run(MRSC);
    issue(MS, mword(3'h5), 3'h0);
    nop_run(1030);
    for (int i = 0; i < 48; i++)
      issue(3'($urandom_range(3, 1)), 21'($urandom), 3'(i));
    issue(WR, 21'h1FFFFE, 3'h7);
    for (int i = 0; i < 5; i++)
      wbeat(i == 1 || (i > 1 && $urandom_range(1)));
    nop_run(2);
    issue(MS, mword(3'h3), 3'h0);
    nop_run(2);
    cal_run(1'b1, 1'b1);
    cal_run(1'b0, 1'b1);
    issue(MS, mword(3'h1), 3'h0);
    nop_run(2);
    cal_run(1'b1, 1'b0);
    cal_run(1'b0, 1'b0);
    issue(MS, 21'h0, 3'h0);
    issue(MS, 21'h0, 3'h0);
    issue(MS, mword(3'h1), 3'h0);
    nop_run(MRSC);
    issue(RF, 21'($urandom), 3'h3);
    nop_run(1030);
    wrap_up();
  end
endmodule
